// ===== logic/acc_conv_ctrl.sv
/*
 * Converter control: registers, free-running sequencing, settle delay,
 * event start, flag handling and the drive of the analog sampling core.
 * Assumes the core returns a done pulse with its result on the mclk domain,
 * and asynchronous pins (event, wake) pass a three-stage synchroniser here.
 */
// The strobed register port and the register addresses were decided locally.
// How it works
// - Clearing free-run lets the current conversion finish, then sequencing stops.
// - Clearing enable aborts free-run at once; nothing new starts afterwards.
// - Config writes in free-run reach the next conversion, latched at its start.
// - Window wake-up disables the converter briefly, forcing a new settle delay.
// - Disabling during an event-started conversion leaves the event pending.
// - Reading the result high byte clears result-ready and window-hit flags.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl
	import acc_pkg::*;
#(
	parameter int unsigned RES_W = 10
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output var  logic [7:0]        rdata,
	input  wire logic              event_start_pin,
	input  wire logic              standby_wake_pin,
	input  wire logic              core_done,
	input  wire logic [RES_W-1:0]  core_result,
	output var  acc_core_ctl_s     core_ctl,
	output var  logic              wake_request
);
	acc_state_e    state_reg;
	logic [7:0]    ctrl_a_reg, ctrl_b_reg, ctrl_c_reg, samp_reg, mux_reg;
	logic [7:0]    window_low_threshold_reg, window_high_threshold_reg, event_control_reg, converter_calibration_reg;
	acc_conv_cfg_s act_cfg_reg;
	logic [RES_W-1:0] result_reg;
	logic          result_ready_flag_reg, winhit_reg, evpend_reg, evconv_reg, sw_start_reg;
	logic [2:0]    ev_sync_reg, wk_sync_reg;
	logic          ev_seen_reg, wk_seen_reg;
	logic [15:0]   cnt_reg;
	logic [2:0]    wake_off_reg;
	logic          hit;
	logic          enable, continuous_conversion_enable, wake_edge, ev_edge, rd_result_high_byte, conv_end, start_now;

	assign enable    = ctrl_a_reg[CA_ENABLE_BIT] && (wake_off_reg == 3'h0);
	assign continuous_conversion_enable   = ctrl_a_reg[CA_CONTINUOUS_CONVERSION_ENABLE_BIT];
	assign ev_edge   = (ev_sync_reg[2] == ev_sync_reg[1]) && ev_sync_reg[1] && !ev_seen_reg;
	assign wake_edge = (wk_sync_reg[2] == wk_sync_reg[1]) && wk_sync_reg[1] && !wk_seen_reg;
	assign rd_result_high_byte   = rd_stb && (addr == OFS_RESULT_HIGH);
	// A completion that meets a disable is dropped, so its event stays pending
	assign conv_end  = (state_reg == ACC_CONV) && core_done && enable;
	assign start_now = (state_reg == ACC_SETTLE) && enable && (cnt_reg == 16'h0)
		&& (sw_start_reg || continuous_conversion_enable || evpend_reg);

	acc_window_cmp #(.RES_W(RES_W)) u_win (
		.result   (core_result),
		.low_thr  (window_low_threshold_reg),
		.high_thr (window_high_threshold_reg),
		.res8     (act_cfg_reg.res8),
		.hit      (hit)
	);

	// Pin synchronisers; a level counts once stages two and three agree
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ev_sync_reg <= 3'h0;
			wk_sync_reg <= 3'h0;
			ev_seen_reg <= 1'b0;
			wk_seen_reg <= 1'b0;
		end else begin
			ev_sync_reg <= {ev_sync_reg[1:0], event_start_pin};
			wk_sync_reg <= {wk_sync_reg[1:0], standby_wake_pin};
			if (ev_sync_reg[2] == ev_sync_reg[1])
				ev_seen_reg <= ev_sync_reg[1];
			if (wk_sync_reg[2] == wk_sync_reg[1])
				wk_seen_reg <= wk_sync_reg[1];
		end
	end

	// Configuration registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_a_reg <= RST_BYTE;
			ctrl_b_reg <= RST_BYTE;
			ctrl_c_reg <= RST_BYTE;
			samp_reg   <= RST_BYTE;
			mux_reg    <= RST_BYTE;
			window_low_threshold_reg  <= RST_BYTE;
			window_high_threshold_reg  <= RST_WIN_HIGH;
			event_control_reg <= RST_BYTE;
			converter_calibration_reg  <= RST_BYTE;
		end else if (wr_stb) begin
			if (addr == OFS_CONTROL_A) begin
				ctrl_a_reg <= wdata;
			end else if (addr == OFS_CONTROL_B) begin
				ctrl_b_reg <= wdata;
			end else if (addr == OFS_CONTROL_C) begin
				ctrl_c_reg <= wdata;
			end else if (addr == OFS_SAMPLE_LEN) begin
				samp_reg <= wdata;
			end else if (addr == OFS_INPUT_SEL) begin
				mux_reg <= wdata;
			end else if (addr == OFS_WIN_LOW) begin
				window_low_threshold_reg <= wdata;
			end else if (addr == OFS_WIN_HIGH) begin
				window_high_threshold_reg <= wdata;
			end else if (addr == OFS_EVENT_CTRL) begin
				event_control_reg <= wdata;
			end else if (addr == OFS_CONVERTER_CALIBRATION) begin
				converter_calibration_reg <= wdata;
			end
		end
	end

	// Software start command
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			sw_start_reg <= 1'b0;
		else if (wr_stb && addr == OFS_COMMAND && wdata[CMD_START_BIT])
			sw_start_reg <= 1'b1;
		else if (state_reg == ACC_CONV || !enable)
			sw_start_reg <= 1'b0;
	end

	// Wake-up holds the converter disabled a few cycles
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			wake_off_reg <= 3'h0;
		else if (wake_edge && winhit_reg)
			wake_off_reg <= 3'(WAKE_OFF_CYC);
		else if (wake_off_reg != 3'h0)
			wake_off_reg <= wake_off_reg - 3'h1;
	end

	// Sequencer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= ACC_IDLE;
			cnt_reg     <= 16'h0;
			act_cfg_reg <= '0;
			evconv_reg  <= 1'b0;
		end else if (!enable) begin
			state_reg <= ACC_IDLE;
			cnt_reg   <= 16'h0;
		end else begin
			case (state_reg)
			ACC_IDLE: begin
				cnt_reg   <= 16'(SETTLE_UNIT_CYC * ({8'h00, ctrl_c_reg} + 16'h1));
				state_reg <= ACC_SETTLE;
			end
			ACC_SETTLE: begin
				if (cnt_reg != 16'h0) begin
					cnt_reg <= cnt_reg - 16'h1;
				end else if (sw_start_reg || continuous_conversion_enable || evpend_reg) begin
					// config is latched here, so later writes wait one conversion
					act_cfg_reg <= '{mux_reg, samp_reg, ctrl_b_reg, ctrl_c_reg,
						ctrl_a_reg[CA_RES8_BIT]};
					evconv_reg  <= evpend_reg && !sw_start_reg && !continuous_conversion_enable;
					state_reg   <= ACC_CONV;
				end
			end
			ACC_CONV: begin
				if (core_done)
					state_reg <= ACC_DONE;
			end
			ACC_DONE: begin
				cnt_reg   <= 16'h0;
				evconv_reg <= 1'b0;
				state_reg <= ACC_SETTLE; // back to settle with count zero; free-run checked there
			end
			default: state_reg <= ACC_IDLE;
			endcase
		end
	end

	// Event pending: cleared only when its conversion completes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			evpend_reg <= 1'b0;
		else if (ev_edge && event_control_reg[EV_START_BIT])
			evpend_reg <= 1'b1;
		else if (conv_end && evconv_reg)
			evpend_reg <= 1'b0;
	end

	// Result and flags; set wins over clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			result_reg <= '0;
			result_ready_flag_reg <= 1'b0;
			winhit_reg <= 1'b0;
		end else begin
			if (conv_end)
				result_reg <= core_result;
			if (conv_end)
				result_ready_flag_reg <= 1'b1;
			else if (rd_result_high_byte || (wr_stb && addr == OFS_FLAGS && wdata[FL_RESULT_READY_FLAG_BIT]))
				result_ready_flag_reg <= 1'b0;
			if (conv_end && hit)
				winhit_reg <= 1'b1;
			else if (rd_result_high_byte || (wr_stb && addr == OFS_FLAGS && wdata[FL_WINHIT_BIT]))
				winhit_reg <= 1'b0;
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (!rd_stb) begin
			rdata <= 8'h00;
		end else if (addr == OFS_CONTROL_A) begin
			rdata <= ctrl_a_reg;
		end else if (addr == OFS_CONTROL_B) begin
			rdata <= ctrl_b_reg;
		end else if (addr == OFS_CONTROL_C) begin
			rdata <= ctrl_c_reg;
		end else if (addr == OFS_SAMPLE_LEN) begin
			rdata <= samp_reg;
		end else if (addr == OFS_INPUT_SEL) begin
			rdata <= mux_reg;
		end else if (addr == OFS_WIN_LOW) begin
			rdata <= window_low_threshold_reg;
		end else if (addr == OFS_WIN_HIGH) begin
			rdata <= window_high_threshold_reg;
		end else if (addr == OFS_EVENT_CTRL) begin
			rdata <= event_control_reg;
		end else if (addr == OFS_CONVERTER_CALIBRATION) begin
			rdata <= converter_calibration_reg;
		end else if (addr == OFS_FLAGS) begin
			rdata <= {6'h00, winhit_reg, result_ready_flag_reg};
		end else if (addr == OFS_RESULT_LOW) begin
			rdata <= result_reg[7:0];
		end else if (addr == OFS_RESULT_HIGH) begin
			rdata <= 8'(result_reg >> 8);
		end else if (addr == OFS_STATUS) begin
			rdata <= {5'h00, evpend_reg, state_reg == ACC_SETTLE, state_reg == ACC_CONV};
		end else begin
			rdata <= 8'h00;
		end
	end

	// Core drive
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			core_ctl     <= '0;
			wake_request <= 1'b0;
		end else begin
			// Input select and sample length go out beside the start pulse, as they are latched
			core_ctl.start      <= start_now;
			core_ctl.duty_25    <= converter_calibration_reg[CAL_DUTY_BIT];
			core_ctl.clk_en     <= enable;
			core_ctl.input_sel  <= start_now ? mux_reg : act_cfg_reg.input_sel;
			core_ctl.sample_len <= start_now ? samp_reg : act_cfg_reg.sample_len;
			wake_request        <= wake_edge && winhit_reg;
		end
	end

	AST_DISABLE_STOPS: assert property (@(posedge mclk) disable iff (!resetn)
		!enable |=> !core_ctl.start) else $error("start after disable");
	AST_RESULT_HIGH_BYTE_CLEARS: assert property (@(posedge mclk) disable iff (!resetn)
		rd_result_high_byte && !conv_end |=> !result_ready_flag_reg && !winhit_reg) else $error("high read kept flags");
	AST_DONE_SETS: assert property (@(posedge mclk) disable iff (!resetn)
		conv_end |=> result_ready_flag_reg) else $error("ready not set");
	AST_EV_STUCK: assert property (@(posedge mclk) disable iff (!resetn)
		evpend_reg && !enable |=> evpend_reg) else $error("event lost on disable");
	AST_WAKE_OFF: assert property (@(posedge mclk) disable iff (!resetn)
		wake_edge && winhit_reg |=> !enable [*4]) else $error("wake hold short");
	AST_CONTINUOUS_CONVERSION_ENABLE_ONE: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == ACC_CONV && enable |=> state_reg != ACC_IDLE) else $error("conv cut");
	AST_CFG_HELD: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == ACC_CONV |=> $stable(act_cfg_reg)) else $error("cfg moved");
	AST_FLAG_W1C: assert property (@(posedge mclk) disable iff (!resetn)
		wr_stb && addr == OFS_FLAGS && wdata[0] && !conv_end |=> !result_ready_flag_reg)
		else $error("w1c failed");
	COV_CONV: cover property (@(posedge mclk) conv_end);
	COV_EV: cover property (@(posedge mclk) conv_end && evconv_reg);
	COV_WAKE: cover property (@(posedge mclk) wake_edge && winhit_reg);
endmodule // acc_conv_ctrl
`default_nettype wire

// ===== logic/acc_pkg.sv
/*
 * Package for the converter control block: register indices, field positions,
 * reset values, timing counts, state encodings and the carrier structs.
 * Assumes a single 250 MHz clock domain and a plain strobe-based register port.
 */
`default_nettype none
package acc_pkg;
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned ADDR_W         = 4;
	// Register indices (byte-wide registers, one per address)
	localparam logic [3:0] OFS_CONTROL_A   = 4'h0;
	localparam logic [3:0] OFS_CONTROL_B   = 4'h1;
	localparam logic [3:0] OFS_CONTROL_C   = 4'h2;
	localparam logic [3:0] OFS_SAMPLE_LEN  = 4'h3;
	localparam logic [3:0] OFS_INPUT_SEL   = 4'h4;
	localparam logic [3:0] OFS_WIN_LOW     = 4'h5;
	localparam logic [3:0] OFS_WIN_HIGH    = 4'h6;
	localparam logic [3:0] OFS_EVENT_CTRL  = 4'h7;
	localparam logic [3:0] OFS_CONVERTER_CALIBRATION       = 4'h8;
	localparam logic [3:0] OFS_FLAGS       = 4'h9;
	localparam logic [3:0] OFS_RESULT_LOW  = 4'ha;
	localparam logic [3:0] OFS_RESULT_HIGH = 4'hb;
	localparam logic [3:0] OFS_COMMAND     = 4'hc;
	localparam logic [3:0] OFS_STATUS      = 4'hd;
	// Field positions
	localparam int unsigned CA_ENABLE_BIT  = 0;
	localparam int unsigned CA_CONTINUOUS_CONVERSION_ENABLE_BIT = 1;
	localparam int unsigned CA_RES8_BIT    = 2;
	localparam int unsigned EV_START_BIT   = 0;
	localparam int unsigned CAL_DUTY_BIT   = 0;
	localparam int unsigned FL_RESULT_READY_FLAG_BIT  = 0;
	localparam int unsigned FL_WINHIT_BIT  = 1;
	localparam int unsigned CMD_START_BIT  = 0;
	localparam int unsigned ST_BUSY_BIT    = 0;
	localparam int unsigned ST_SETTLE_BIT  = 1;
	localparam int unsigned ST_EVPEND_BIT  = 2;
	// Reset values
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [7:0] RST_WIN_HIGH    = 8'hff;
	// Timing: settle delay per unit and conversion length
	localparam int unsigned SETTLE_UNIT_NS = 64;
	localparam int unsigned SETTLE_UNIT_CYC = (SETTLE_UNIT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CONV_BASE_NS   = 200;
	localparam int unsigned CONV_BASE_CYC  = (CONV_BASE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned WAKE_OFF_CYC   = 4;

	typedef enum logic [3:0] {
		ACC_IDLE   = 4'b0001,
		ACC_SETTLE = 4'b0010,
		ACC_CONV   = 4'b0100,
		ACC_DONE   = 4'b1000
	} acc_state_e;

	typedef struct packed {
		logic [7:0] input_sel;
		logic [7:0] sample_len;
		logic [7:0] control_b;
		logic [7:0] control_c;
		logic       res8;
	} acc_conv_cfg_s;

	typedef struct packed {
		logic       start;
		logic       duty_25;
		logic       clk_en;
		logic [7:0] input_sel;
		logic [7:0] sample_len;
	} acc_core_ctl_s;
endpackage
`default_nettype wire

// ===== logic/acc_window_cmp.sv
/*
 * Window comparator: flags a hit when the result lies outside the
 * low/high thresholds. Assumes thresholds are stable during a compare.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_window_cmp
	import acc_pkg::*;
#(
	parameter int unsigned RES_W = 10
) (
	input  wire logic [RES_W-1:0] result,
	input  wire logic [7:0]       low_thr,
	input  wire logic [7:0]       high_thr,
	input  wire logic             res8,
	output var  logic             hit
);
	logic [7:0] res_top;

	always_comb begin
		res_top = res8 ? result[7:0] : result[RES_W-1:RES_W-8];
		hit     = (res_top < low_thr) || (res_top > high_thr);
	end
endmodule // acc_window_cmp
`default_nettype wire

// ===== tb/acc_core_model.sv
/*
 * Model of the analog sampling core: answers each start pulse with a done
 * pulse and a result, promptly or slowly.
 * Assumes start pulses arrive on mclk and the next result is set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module acc_core_model
	import acc_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          resetn,
	input  wire acc_core_ctl_s core_ctl,
	input  wire logic          slow,
	input  wire logic [9:0]    next_result,
	output var  logic          core_done,
	output var  logic [9:0]    core_result
);
	initial begin
		core_done = 1'b0;
		core_result = 10'h3ff;
	end
	always begin
		@(posedge mclk);
		if (resetn && core_ctl.start) begin
			repeat (slow ? 40 : 3) @(posedge mclk);
			core_done   <= 1'b1;
			core_result <= next_result;
			@(posedge mclk);
			core_done   <= 1'b0;
			// Result is only meaningful beside done
			core_result <= ~next_result;
		end
	end
endmodule // acc_core_model
`default_nettype wire

// ===== tb/test_acc_conv_ctrl.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the core model beside it and the register port of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module test_acc_conv_ctrl
	import acc_pkg::*;
;
	logic          mclk, resetn, wr_stb, rd_stb, ev_pin, wk_pin, slow, core_done, wake_request, rd_d;
	logic [3:0]    addr;
	logic [7:0]    wdata, rdata, sel_exp, v;
	logic [9:0]    core_result, next_result, r;
	acc_core_ctl_s core_ctl;
	logic [15:0]   q[$];
	int            fails, n_checks, n_starts, n_wakes, n, i, seed;

	acc_conv_ctrl #(.RES_W(10)) acc_conv_ctrl_inst (
		.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.event_start_pin(ev_pin), .standby_wake_pin(wk_pin),
		.core_done(core_done), .core_result(core_result),
		.core_ctl(core_ctl), .wake_request(wake_request));
	acc_core_model acc_core_model_inst (
		.mclk(mclk), .resetn(resetn), .core_ctl(core_ctl), .slow(slow),
		.next_result(next_result), .core_done(core_done), .core_result(core_result));

	always #2 mclk = ~mclk;

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a; wdata <= d; wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		q.push_back({m, e & m});
		addr <= a; rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(posedge mclk);
	endtask
	task wait_starts(input int k);
		for (int j = 0; j < 2000 && n_starts < k; j++) @(posedge mclk);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_d) begin
			chk(rdata & q[0][15:8], q[0][7:0]);
			void'(q.pop_front());
		end
		rd_d <= rd_stb;
		if (wake_request)
			n_wakes++;
		if (core_ctl.start) begin
			n_starts++;
			chk(core_ctl.input_sel, sel_exp);
			chk(core_ctl.sample_len, sel_exp);
			chk({7'h00, core_ctl.clk_en}, 8'h01);
			chk({7'h00, core_ctl.duty_25}, 8'h00);
		end
	end

	initial begin
		#(4 * 30000);
		fails++;
		tally_and_finish;
	end

	initial begin
		mclk = 0; resetn = 0; addr = 0; wdata = 0; wr_stb = 0; rd_stb = 0; wk_pin = 0;
		ev_pin = 0; slow = 0; next_result = 0; sel_exp = 0; seed = 25;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		rd(OFS_CONTROL_A, RST_BYTE, 8'hff);
		rd(OFS_WIN_HIGH, RST_WIN_HIGH, 8'hff);
		wr(4'he, 8'($random(seed)));
		rd(4'he, 8'h00, 8'hff);
		// Input select, sample length, calibration and settle length land while free-run is off
		v = 8'($random(seed));
		sel_exp <= v;
		wr(OFS_INPUT_SEL, v);
		wr(OFS_SAMPLE_LEN, v);
		wr(OFS_CONVERTER_CALIBRATION, 8'h00);
		wr(OFS_CONTROL_C, 8'h00);
		wr(OFS_CONTROL_A, 8'h01);
		repeat (2 * SETTLE_UNIT_CYC) @(posedge mclk);
		for (i = 0; i < 3; i++) begin
			r = 10'($random(seed));
			next_result <= r;
			n = n_starts;
			wr(OFS_COMMAND, 8'h01);
			wait_starts(n + 1);
			repeat (8) @(posedge mclk);
			rd(OFS_RESULT_LOW, r[7:0], 8'hff);
			rd(OFS_FLAGS, 8'h01, 8'h01);
			if (i == 2) begin
				wr(OFS_FLAGS, 8'h01);
				rd(OFS_FLAGS, 8'h00, 8'h01);
			end else begin
				rd(OFS_RESULT_HIGH, {6'h00, r[9:8]}, 8'hff);
				rd(OFS_FLAGS, 8'h00, 8'h03);
			end
		end
		slow <= 1'b1;
		wr(OFS_CONTROL_A, 8'h03);
		wait_starts(n_starts + 2);
		n = n_starts;
		wr(OFS_CONTROL_A, 8'h01);
		repeat (150) @(posedge mclk);
		chk({7'h00, (n_starts - n) > 1}, 8'h00);
		wr(OFS_CONTROL_A, 8'h03);
		wait_starts(n_starts + 1);
		wr(OFS_CONTROL_A, 8'h00);
		n = n_starts;
		repeat (150) @(posedge mclk);
		chk(8'(n_starts - n), 8'h00);
		// Disable in mid event conversion, skipping the safe sequence
		wr(OFS_CONTROL_A, 8'h01);
		repeat (2 * SETTLE_UNIT_CYC) @(posedge mclk);
		wr(OFS_EVENT_CTRL, 8'h01);
		n = n_starts;
		ev_pin <= 1'b1;
		wait_starts(n + 1);
		wr(OFS_CONTROL_A, 8'h00);
		rd(OFS_STATUS, 8'h04, 8'h04);
		chk(8'(n_starts - n), 8'h01);
		// Window hit, then a standby wake must force a fresh settle delay
		slow <= 1'b0;
		next_result <= 10'h000;
		repeat (50) @(posedge mclk);
		wr(OFS_WIN_LOW, 8'hff);
		n = n_starts;
		wr(OFS_CONTROL_A, 8'h01);
		wait_starts(n + 1);
		repeat (8) @(posedge mclk);
		rd(OFS_FLAGS, 8'h03, 8'h03);
		wk_pin <= 1'b1;
		repeat (10) @(posedge mclk);
		n = n_starts;
		wr(OFS_COMMAND, 8'h01);
		repeat (SETTLE_UNIT_CYC - 4) @(posedge mclk);
		chk(8'(n_starts - n), 8'h00);
		chk(8'(n_wakes), 8'h01);
		wait_starts(n + 1);
		wr(OFS_EVENT_CTRL, 8'h00);
		repeat (8) @(posedge mclk);
		wr(OFS_CONTROL_A, 8'h00);
		chk(8'(n_starts - n), 8'h01);
		rd(OFS_STATUS, 8'h00, 8'h07);
		tally_and_finish;
	end
endmodule // test_acc_conv_ctrl
`default_nettype wire
